// >>> lac_pkg.sv
// Shared codes, timing figures and message layouts for the line activation control link.
package lac_pkg;
    localparam int CLK_HZ        = 20000000;
    localparam int CI_W          = 4;
    localparam int FEED_W        = 8;
    localparam int MSG_W         = 16;
    localparam int FRAME_BITS    = 32;
    localparam int B1_FIRST_BIT  = 0;
    localparam int CI_PERSIST    = 2;
    localparam int WARM_MS       = 300;
    localparam int COLD_MS       = 1000;
    localparam int WARM_CYCLES   = CLK_HZ / 1000 * WARM_MS;
    localparam int COLD_CYCLES   = CLK_HZ / 1000 * COLD_MS;
    localparam int LINK_DIV      = 4;

    localparam logic [CI_W-1:0] CI_DEACT_REQ  = 4'h0;
    localparam logic [CI_W-1:0] CI_SHUTDOWN   = 4'h1;
    localparam logic [CI_W-1:0] CI_FEED_OFF   = 4'h3;
    localparam logic [CI_W-1:0] CI_LINE_DIS   = 4'h3;
    localparam logic [CI_W-1:0] CI_RESET      = 4'h1;
    localparam logic [CI_W-1:0] CI_U_ONLY     = 4'h7;
    localparam logic [CI_W-1:0] CI_ACT_REQ    = 4'h8;
    localparam logic [CI_W-1:0] CI_ACT_IND    = 4'hc;
    localparam logic [CI_W-1:0] CI_ACT_NOACT  = 4'hd;
    localparam logic [CI_W-1:0] CI_DEACT_CONF = 4'hf;
    localparam logic [CI_W-1:0] CI_DEACT_IND  = 4'hf;

    localparam logic [7:0] MSG_LOCAL      = 8'h80;
    localparam logic [7:0] MSG_READ_FEED  = 8'h90;
    localparam logic [7:0] MSG_FEED_ANS   = 8'h91;
    localparam logic [7:0] MSG_U_TWO      = 8'ha0;
    localparam logic [7:0] MSG_UOA_SET    = 8'h01;

    typedef enum logic [2:0] {
        ST_TEST      = 3'b000,
        ST_DEACT     = 3'b001,
        ST_ACTIVATE  = 3'b010,
        ST_U_ONLY    = 3'b011,
        ST_ACTIVE    = 3'b100,
        ST_SHUTDOWN  = 3'b101
    } line_state_t;
endpackage

// >>> lac_if.sv
// Serial frame link between the line side device and its exchange controller.
`timescale 1ns/1ps
`default_nettype none
interface lac_if;
    logic link_clk;
    logic frame_sync;
    logic down_data;
    logic up_data;
    modport device (
        input  link_clk,
        input  frame_sync,
        input  down_data,
        output up_data
    );
    modport controller (
        output link_clk,
        output frame_sync,
        output down_data,
        input  up_data
    );
endinterface
`default_nettype wire

// >>> lac_controller.sv
// Exchange controller end: makes the frame clock and shifts codes and messages.
`timescale 1ns/1ps
`default_nettype none
module lac_controller
    import lac_pkg::*;
#(
    parameter int DIV = LINK_DIV
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    lac_if.controller              link,
    input  wire logic [CI_W-1:0]   ci_cmd_i,
    input  wire logic [MSG_W-1:0]  msg_cmd_i,
    input  wire logic              msg_valid_i,
    output logic                   msg_ready_o,
    output logic [CI_W-1:0]        ci_ind_o,
    output logic [MSG_W-1:0]       msg_ans_o,
    output logic                   msg_ans_valid_o
);
    // The controller makes the link clock; data changes on its falling edge.
    logic [7:0]            div_r;
    logic                  lclk_r;
    logic [4:0]            bit_r;
    logic [FRAME_BITS-1:0] tx_r;
    logic [FRAME_BITS-1:0] rx_r;
    logic                  fs_r;
    logic                  sd_r;
    logic [MSG_W-1:0]      pend_r;
    logic                  pend_v_r;
    logic [CI_W-1:0]       ci_last_r;
    logic [CI_W-1:0]       ci_ind_r;
    logic [MSG_W-1:0]      ans_r;
    logic                  ans_v_r;
    logic                  rise;
    logic                  fall;

    assign rise = (div_r == 8'(DIV - 1)) && !lclk_r;
    assign fall = (div_r == 8'(DIV - 1)) && lclk_r;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            div_r  <= 8'h00;
            lclk_r <= 1'b0;
        end else if (div_r == 8'(DIV - 1)) begin
            div_r  <= 8'h00;
            lclk_r <= !lclk_r;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pend_r   <= '0;
            pend_v_r <= 1'b0;
        end else if (msg_valid_i && !pend_v_r) begin
            pend_r   <= msg_cmd_i;
            pend_v_r <= 1'b1;
        end else if (fall && bit_r == 5'h1f) begin
            pend_v_r <= 1'b0;
        end
    end

    // Frame: code in 31:28, message valid 27, message 26:11.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            bit_r <= 5'h1f;
            tx_r  <= '0;
            fs_r  <= 1'b0;
            sd_r  <= 1'b0;
        end else if (fall) begin
            bit_r <= bit_r + 5'h01;
            if (bit_r == 5'h1f) begin
                tx_r <= {ci_cmd_i, pend_v_r, pend_v_r ? pend_r : {MSG_W{1'b0}}, 11'h000};
                fs_r <= 1'b1;
                sd_r <= ci_cmd_i[CI_W-1];
            end else begin
                tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
                fs_r <= 1'b0;
                sd_r <= tx_r[FRAME_BITS-2];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_r      <= '0;
            ci_last_r <= CI_DEACT_IND;
            ci_ind_r  <= CI_DEACT_IND;
            ans_r     <= '0;
            ans_v_r   <= 1'b0;
        end else begin
            ans_v_r <= 1'b0;
            if (rise) begin
                rx_r <= {rx_r[FRAME_BITS-2:0], link.up_data};
                if (bit_r == 5'h1f) begin
                    ci_last_r <= rx_r[FRAME_BITS-2:FRAME_BITS-1-CI_W];
                    if (rx_r[FRAME_BITS-2:FRAME_BITS-1-CI_W] == ci_last_r) begin
                        ci_ind_r <= ci_last_r;
                    end
                    if (rx_r[FRAME_BITS-1-CI_W-1]) begin
                        ans_r   <= rx_r[FRAME_BITS-3-CI_W:10];
                        ans_v_r <= 1'b1;
                    end
                end
            end
        end
    end

    assign link.link_clk   = lclk_r;
    assign link.frame_sync = fs_r;
    assign link.down_data  = sd_r;
    assign msg_ready_o     = !pend_v_r;
    assign ci_ind_o        = ci_ind_r;
    assign msg_ans_o       = ans_r;
    assign msg_ans_valid_o = ans_v_r;
endmodule // lac_controller
`default_nettype wire

// >>> lac_device.sv
// Line activation control of the transceiver: code interpreter, feed pins and start-up timing.
`timescale 1ns/1ps
`default_nettype none
module lac_device
    import lac_pkg::*;
#(
    parameter int COLD_CNT = COLD_CYCLES,
    parameter int WARM_CNT = WARM_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    lac_if.device           link,
    input  wire logic       network_mode_i,
    input  wire logic       auto_mode_i,
    input  wire logic       primary_supply_status_pin_i,
    input  wire logic       secondary_supply_status_pin_i,
    input  wire logic       line_up_i,
    input  wire logic       far_test_i,
    input  wire logic       terminal_req_i,
    input  wire logic       eoc_loop_i,
    input  wire logic       eoc_return_i,
    output logic            feed_disable_out_o,
    output logic            m42_o,
    output logic            m43_o,
    output logic            u_only_activation_flag_o,
    output logic            coeff_reuse_o,
    output logic [2:0]      state_o
);
    // Two-stage synchronisers for the supply and EOC pins and the link signals.
    localparam int NS = 7;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    logic [NS-1:0] raw;
    assign raw = {link.link_clk, link.frame_sync, link.down_data,
                  primary_supply_status_pin_i, secondary_supply_status_pin_i,
                  eoc_loop_i, eoc_return_i};
    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (!resetn_i) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= raw[g];
                    s2_r[g] <= s1_r[g];
                end
            end
        end
    endgenerate
    logic lclk_s, fs_s, dd_s, ps1_s, ps2_s, loop_s, ret_s;
    assign {lclk_s, fs_s, dd_s, ps1_s, ps2_s, loop_s, ret_s} = s2_r;

    logic lclk_d_r, loop_d_r, ret_d_r;
    logic rise, fall, loop_ev, ret_ev;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            lclk_d_r <= 1'b0;
            loop_d_r <= 1'b0;
            ret_d_r  <= 1'b0;
        end else begin
            lclk_d_r <= lclk_s;
            loop_d_r <= loop_s;
            ret_d_r  <= ret_s;
        end
    end
    assign rise    = lclk_s && !lclk_d_r;
    assign fall    = !lclk_s && lclk_d_r;
    assign loop_ev = loop_s && !loop_d_r;
    assign ret_ev  = ret_s && !ret_d_r;

    // Frame receive: bit counter restarts on frame sync.
    logic [4:0]            bit_r;
    logic [FRAME_BITS-1:0] rx_r;
    logic [FEED_W-1:0]     feed_sh_r;
    logic [FEED_W-1:0]     feed_val_r;
    logic [CI_W-1:0]       ci_last_r;
    logic [CI_W-1:0]       ci_cmd_r;
    logic                  frame_end;
    logic                  msg_v;
    logic [MSG_W-1:0]      msg;
    assign frame_end = rise && (bit_r == 5'h1f);
    assign msg_v     = frame_end && rx_r[FRAME_BITS-1-CI_W-1];
    assign msg       = rx_r[FRAME_BITS-3-CI_W:10];

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            bit_r <= 5'h00;
            rx_r  <= '0;
        end else if (rise) begin
            bit_r <= fs_s ? 5'h01 : bit_r + 5'h01;
            rx_r  <= {rx_r[FRAME_BITS-2:0], dd_s};
        end
    end

    // Feed current is shifted in during the B1 slot.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            feed_sh_r  <= '0;
            feed_val_r <= '0;
        end else if (rise) begin
            if (bit_r < 5'(B1_FIRST_BIT + FEED_W)) begin
                feed_sh_r <= {feed_sh_r[FEED_W-2:0], ps2_s};
            end
            if (bit_r == 5'(B1_FIRST_BIT + FEED_W)) begin
                feed_val_r <= feed_sh_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        // Reset to the idle request code, so a confirm code held through reset is still new.
        if (!resetn_i) begin
            ci_last_r <= CI_DEACT_REQ;
            ci_cmd_r  <= CI_DEACT_REQ;
        end else if (frame_end) begin
            ci_last_r <= rx_r[FRAME_BITS-2:FRAME_BITS-1-CI_W];
            if (rx_r[FRAME_BITS-2:FRAME_BITS-1-CI_W] == ci_last_r) begin
                ci_cmd_r <= ci_last_r;
            end
        end
    end
    logic cmd_new;
    logic [CI_W-1:0] ci_prev_r;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) ci_prev_r <= CI_DEACT_REQ;
        else ci_prev_r <= ci_cmd_r;
    end
    assign cmd_new = ci_cmd_r != ci_prev_r;

    // Feed disable pin: reset code does not touch it.
    logic dis_r;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dis_r <= 1'b0;
        end else if (!network_mode_i && cmd_new && ci_cmd_r == CI_LINE_DIS) begin
            dis_r <= 1'b1;
        end else if (network_mode_i && auto_mode_i && loop_ev) begin
            dis_r <= 1'b1;
        end else if (network_mode_i && ret_ev) begin
            dis_r <= 1'b0;
        end
    end

    // Activation state machine.
    line_state_t st_r;
    logic        uoa_r, warm_r, tried_r, from_test_r;
    logic [31:0] tmr_r;
    logic        lt_feed_off;
    assign lt_feed_off = !network_mode_i && ps1_s;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_r        <= ST_TEST;
            uoa_r       <= 1'b1;
            warm_r      <= 1'b0;
            tried_r     <= 1'b0;
            from_test_r <= 1'b1;
            tmr_r       <= '0;
        end else if (lt_feed_off || dis_r) begin
            st_r   <= ST_TEST;
            warm_r <= 1'b1;
        end else begin
            if (msg_v && msg[15:8] == MSG_U_TWO && msg[7:0] == MSG_UOA_SET) begin
                uoa_r <= 1'b1;
            end
            case (st_r)
                ST_TEST: begin
                    if (cmd_new && ci_cmd_r == CI_RESET) begin
                        st_r        <= ST_DEACT;
                        from_test_r <= 1'b1;
                    end else if (cmd_new && ci_cmd_r == CI_DEACT_CONF) begin
                        st_r        <= ST_DEACT;
                        from_test_r <= 1'b0;
                    end
                end
                ST_DEACT: begin
                    if (cmd_new && ci_cmd_r == CI_DEACT_CONF) from_test_r <= 1'b0;
                    if (cmd_new && (ci_cmd_r == CI_ACT_REQ || ci_cmd_r == CI_ACT_NOACT)) begin
                        st_r  <= ST_ACTIVATE;
                        uoa_r <= ci_cmd_r == CI_ACT_REQ;
                        tmr_r <= '0;
                    end else if (terminal_req_i && !from_test_r
                                 && ci_cmd_r == CI_DEACT_CONF) begin
                        st_r <= ST_ACTIVATE;
                        tmr_r <= '0;
                    end else if (network_mode_i && auto_mode_i && !tried_r) begin
                        tried_r <= 1'b1;
                        st_r    <= ST_ACTIVATE;
                        tmr_r   <= '0;
                    end
                end
                ST_ACTIVATE: begin
                    tmr_r <= tmr_r + 32'h1;
                    if (far_test_i) begin
                        st_r <= ST_DEACT;
                    end else if (line_up_i
                                 && tmr_r >= 32'(warm_r ? WARM_CNT : COLD_CNT)) begin
                        st_r   <= uoa_r ? ST_ACTIVE : ST_U_ONLY;
                        warm_r <= 1'b0;
                    end
                end
                ST_U_ONLY, ST_ACTIVE: begin
                    if (cmd_new && ci_cmd_r == CI_DEACT_REQ) begin
                        st_r <= ST_SHUTDOWN;
                    end else if (st_r == ST_U_ONLY && (uoa_r
                                 || (cmd_new && ci_cmd_r == CI_ACT_REQ)
                                 || (terminal_req_i && ci_cmd_r == CI_DEACT_CONF))) begin
                        st_r <= ST_ACTIVE;
                    end
                end
                ST_SHUTDOWN: begin
                    if (ci_cmd_r == CI_DEACT_CONF) st_r <= ST_DEACT;
                end
                default: st_r <= ST_TEST;
            endcase
        end
    end

    // Upstream frame: indication, answer valid, answer message.
    logic [CI_W-1:0]       ind;
    logic                  ans_pend_r;
    logic [FRAME_BITS-1:0] tx_r;
    logic                  up_r;
    always_comb begin
        case (st_r)
            ST_TEST:     ind = lt_feed_off ? CI_FEED_OFF : CI_DEACT_REQ;
            ST_DEACT:    ind = CI_DEACT_IND;
            ST_ACTIVATE: ind = CI_ACT_REQ;
            ST_U_ONLY:   ind = CI_U_ONLY;
            ST_ACTIVE:   ind = CI_ACT_IND;
            ST_SHUTDOWN: ind = CI_SHUTDOWN;
            default:     ind = CI_DEACT_IND;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ans_pend_r <= 1'b0;
            tx_r       <= '0;
            up_r       <= 1'b0;
        end else begin
            if (msg_v && msg[15:8] == MSG_READ_FEED) ans_pend_r <= 1'b1;
            if (fall) begin
                if (bit_r == 5'h00) begin
                    tx_r <= {ind, ans_pend_r, MSG_FEED_ANS, feed_val_r, 11'h000};
                    up_r <= ind[CI_W-1];
                    ans_pend_r <= msg_v && msg[15:8] == MSG_READ_FEED;
                end else begin
                    tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
                    up_r <= tx_r[FRAME_BITS-2];
                end
            end
        end
    end

    // Overhead bits follow the supply pins in network mode.
    logic m42_r, m43_r;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            m42_r <= 1'b0;
            m43_r <= 1'b0;
        end else begin
            m42_r <= network_mode_i & ps1_s;
            m43_r <= network_mode_i & ps2_s;
        end
    end

    assign link.up_data             = up_r;
    assign feed_disable_out_o       = dis_r;
    assign m42_o                    = m42_r;
    assign m43_o                    = m43_r;
    assign u_only_activation_flag_o = uoa_r;
    assign coeff_reuse_o            = warm_r;
    assign state_o                  = st_r;
endmodule // lac_device
`default_nettype wire

// >>> lac_monitor.sv
// Concurrent checks on the frame link and the device pins.
`timescale 1ns/1ps
`default_nettype none
module lac_monitor
    import lac_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       link_clk,
    input wire logic       frame_sync,
    input wire logic       network_mode_i,
    input wire logic       auto_mode_i,
    input wire logic       primary_supply_status_pin_i,
    input wire logic       secondary_supply_status_pin_i,
    input wire logic       eoc_loop_i,
    input wire logic       eoc_return_i,
    input wire logic       feed_disable_out_o,
    input wire logic       m42_o,
    input wire logic       m43_o,
    input wire logic [2:0] state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_clk_half;
        $rose(link_clk) |-> link_clk[*4] ##1 !link_clk;
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("link clock half period wrong");
    property p_sync_len;
        $rose(frame_sync) |-> frame_sync[*8] ##1 !frame_sync;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("frame sync width wrong");
    property p_frame_len;
        $rose(frame_sync) |-> ##256 $rose(frame_sync);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    property p_m42;
        (network_mode_i && primary_supply_status_pin_i)[*6] |-> m42_o;
    endproperty
    a_m42: assert property (p_m42) else $error("m42 does not follow pin");
    property p_m43;
        (network_mode_i && !secondary_supply_status_pin_i)[*6] |-> !m43_o;
    endproperty
    a_m43: assert property (p_m43) else $error("m43 does not follow pin");
    property p_hold_test;
        $past(feed_disable_out_o) && feed_disable_out_o |-> state_o == ST_TEST;
    endproperty
    a_hold_test: assert property (p_hold_test) else $error("left test with feed off");
    property p_loop;
        network_mode_i && auto_mode_i && $rose(eoc_loop_i) |-> ##[1:6] feed_disable_out_o;
    endproperty
    a_loop: assert property (p_loop) else $error("loop command ignored");
    property p_return;
        network_mode_i && auto_mode_i && $rose(eoc_return_i) |-> ##[1:6] !feed_disable_out_o;
    endproperty
    a_return: assert property (p_return) else $error("return command ignored");
    property p_feed_off;
        (!network_mode_i && primary_supply_status_pin_i)[*6] |-> state_o == ST_TEST;
    endproperty
    a_feed_off: assert property (p_feed_off) else $error("supply pin high outside test");
    c_u_only: cover property (state_o == ST_U_ONLY);
    c_shutdown: cover property (state_o == ST_SHUTDOWN);
    c_disable: cover property ($rose(feed_disable_out_o));
endmodule // lac_monitor
`default_nettype wire

// >>> u_line_activation_control_tb.sv
// Testbench joining controller and device ends over the frame link.
`timescale 1ns/1ps
`default_nettype none
module u_line_activation_control_tb
    import lac_pkg::*;
;
    localparam int DLY = 2;
    localparam int COLD_T = 20;
    localparam int WARM_T = 10;
    logic             clk_i = 1'b0;
    logic             resetn_i = 1'b0;
    logic [CI_W-1:0]  ci_cmd = CI_DEACT_REQ;
    logic [MSG_W-1:0] msg_cmd = 16'h0000;
    logic             msg_valid = 1'b0;
    logic             msg_ready;
    logic [CI_W-1:0]  ci_ind;
    logic [MSG_W-1:0] msg_ans;
    logic             msg_ans_valid;
    logic             network = 1'b0;
    logic             auto = 1'b0;
    logic             primary = 1'b0;
    logic             secondary = 1'b0;
    logic             line_up = 1'b0;
    logic             far_test = 1'b0;
    logic             eoc_loop = 1'b0;
    logic             eoc_return = 1'b0;
    logic             terminal = 1'b0;
    logic             feed_dis;
    logic             m42;
    logic             m43;
    logic             u_only_activation_flag;
    logic             warm;
    logic [2:0]       state;
    logic [7:0]       feed_val = 8'h00;
    logic             feed_on = 1'b0;
    int               bad_count = 0;
    int               tests_run = 0;

    always #25 clk_i = ~clk_i;

    lac_if lac_if_i ();
    lac_controller #(.DIV(LINK_DIV)) lac_controller_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .link(lac_if_i), .ci_cmd_i(ci_cmd),
        .msg_cmd_i(msg_cmd), .msg_valid_i(msg_valid), .msg_ready_o(msg_ready),
        .ci_ind_o(ci_ind), .msg_ans_o(msg_ans), .msg_ans_valid_o(msg_ans_valid));
    lac_device #(.COLD_CNT(COLD_T), .WARM_CNT(WARM_T)) lac_device_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .link(lac_if_i), .network_mode_i(network),
        .auto_mode_i(auto), .primary_supply_status_pin_i(primary),
        .secondary_supply_status_pin_i(secondary), .line_up_i(line_up),
        .far_test_i(far_test), .terminal_req_i(terminal), .eoc_loop_i(eoc_loop),
        .eoc_return_i(eoc_return), .feed_disable_out_o(feed_dis), .m42_o(m42),
        .m43_o(m43), .u_only_activation_flag_o(u_only_activation_flag), .coeff_reuse_o(warm), .state_o(state));
    lac_monitor lac_monitor_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .link_clk(lac_if_i.link_clk),
        .frame_sync(lac_if_i.frame_sync), .network_mode_i(network), .auto_mode_i(auto),
        .primary_supply_status_pin_i(primary), .secondary_supply_status_pin_i(secondary),
        .eoc_loop_i(eoc_loop), .eoc_return_i(eoc_return), .feed_disable_out_o(feed_dis),
        .m42_o(m42), .m43_o(m43), .state_o(state));

    // The power controller shifts the current value MSB first into frame bits 0 to 7.
    always begin
        @(posedge lac_if_i.frame_sync);
        for (int i = 7; i >= 0; i--) begin
            #DLY;
            secondary = feed_on ? feed_val[i] : secondary;
            @(negedge lac_if_i.link_clk);
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #DLY;
    endtask
    task automatic wait_state(input logic [2:0] s);
        for (int i = 0; i < 3000 && state !== s; i++) tick(1);
    endtask
    task automatic go(input logic [CI_W-1:0] c, input logic [2:0] s);
        ci_cmd = c;
        wait_state(s);
    endtask
    task automatic do_reset;
        resetn_i = 1'b0;
        tick(20);
        resetn_i = 1'b1;
        tick(1);
    endtask
    task automatic send_msg(input logic [MSG_W-1:0] m);
        logic rdy;
        msg_cmd = m;
        msg_valid = 1'b1;
        for (int i = 0; i < 2000; i++) begin
            rdy = msg_ready;
            tick(1);
            if (rdy === 1'b1) break;
        end
        msg_valid = 1'b0;
    endtask
    task automatic t_reset_vals;
        check(state, ST_TEST);
        check(feed_dis, 1'b0);
        check(u_only_activation_flag, 1'b1);
        tick(256 * 4);
        check(ci_ind, CI_DEACT_REQ);
    endtask
    task automatic t_activation;
        go(CI_DEACT_CONF, ST_DEACT);
        check(state, ST_DEACT);
        line_up = 1'b1;
        go(CI_ACT_NOACT, ST_ACTIVATE);
        check(state, ST_ACTIVATE);
        check(u_only_activation_flag, 1'b0);
        tick(WARM_T + 2);
        check(state, ST_ACTIVATE);
        wait_state(ST_U_ONLY);
        check(state, ST_U_ONLY);
        send_msg({MSG_U_TWO, MSG_UOA_SET});
        tick(256 * 3);
        check(u_only_activation_flag, 1'b1);
        go(CI_DEACT_REQ, ST_SHUTDOWN);
        check(state, ST_SHUTDOWN);
        go(CI_DEACT_CONF, ST_DEACT);
        check(state, ST_DEACT);
        tick(256 * 4);
        check(state, ST_DEACT);
        go(CI_ACT_NOACT, ST_U_ONLY);
        terminal = 1'b1;
        tick(256 * 3);
        check(state, ST_U_ONLY);
        terminal = 1'b0;
        go(CI_ACT_REQ, ST_ACTIVE);
        check(state, ST_ACTIVE);
        go(CI_DEACT_REQ, ST_SHUTDOWN);
        go(CI_DEACT_CONF, ST_DEACT);
        terminal = 1'b1;
        wait_state(ST_ACTIVATE);
        check(state, ST_ACTIVATE);
        wait_state(ST_ACTIVE);
        check(state, ST_ACTIVE);
        terminal = 1'b0;
        go(CI_DEACT_REQ, ST_SHUTDOWN);
        go(CI_DEACT_CONF, ST_DEACT);
        line_up = 1'b0;
    endtask
    task automatic t_feed;
        logic [7:0] vals [2] = '{8'ha5, 8'h3c};
        feed_on = 1'b1;
        foreach (vals[k]) begin
            feed_val = vals[k];
            tick(256 * 3);
            send_msg({MSG_READ_FEED, 8'h00});
            for (int i = 0; i < 1000 && msg_ans_valid !== 1'b1; i++) tick(1);
            check(msg_ans_valid, 1'b1);
            check(msg_ans, {MSG_FEED_ANS, vals[k]});
        end
        feed_on = 1'b0;
    endtask
    task automatic t_disable;
        ci_cmd = CI_LINE_DIS;
        for (int i = 0; i < 2000 && feed_dis !== 1'b1; i++) tick(1);
        check(feed_dis, 1'b1);
        tick(1);
        check(state, ST_TEST);
        ci_cmd = CI_RESET;
        tick(256 * 4);
        check(feed_dis, 1'b1);
        ci_cmd = CI_ACT_REQ;
        tick(256 * 4);
        check(state, ST_TEST);
        ci_cmd = CI_DEACT_REQ;
        do_reset();
        check(feed_dis, 1'b0);
    endtask
    task automatic t_feed_off;
        go(CI_RESET, ST_DEACT);
        check(state, ST_DEACT);
        terminal = 1'b1;
        tick(256 * 3);
        check(state, ST_DEACT);
        terminal = 1'b0;
        primary = 1'b1;
        wait_state(ST_TEST);
        check(state, ST_TEST);
        for (int i = 0; i < 2000 && ci_ind !== CI_FEED_OFF; i++) tick(1);
        check(ci_ind, CI_FEED_OFF);
        primary = 1'b0;
        check(warm, 1'b1);
        go(CI_DEACT_CONF, ST_DEACT);
        line_up = 1'b1;
        go(CI_ACT_REQ, ST_ACTIVATE);
        tick(WARM_T + 2);
        check(state, ST_ACTIVE);
        check(warm, 1'b0);
        go(CI_DEACT_REQ, ST_SHUTDOWN);
        go(CI_DEACT_CONF, ST_DEACT);
        line_up = 1'b0;
    endtask
    task automatic t_network;
        network = 1'b1;
        for (int i = 0; i < 4; i++) begin
            primary = i[1];
            secondary = i[0];
            tick(8);
            check(m42, i[1]);
            check(m43, i[0]);
        end
        primary = 1'b0;
        secondary = 1'b0;
        network = 1'b0;
    endtask
    task automatic t_auto;
        network = 1'b1;
        auto = 1'b1;
        far_test = 1'b1;
        do_reset();
        wait_state(ST_ACTIVATE);
        check(state, ST_ACTIVATE);
        wait_state(ST_DEACT);
        check(state, ST_DEACT);
        tick(256 * 6);
        check(state, ST_DEACT);
        eoc_loop = 1'b1;
        tick(8);
        check(feed_dis, 1'b1);
        eoc_loop = 1'b0;
        eoc_return = 1'b1;
        tick(8);
        check(feed_dis, 1'b0);
        eoc_return = 1'b0;
    endtask

    initial begin
        #4000000;
        bad_count++;
        end_sim();
    end
    initial begin
        do_reset();
        t_reset_vals();
        t_activation();
        t_feed();
        t_disable();
        t_feed_off();
        t_network();
        t_auto();
        end_sim();
    end
endmodule // u_line_activation_control_tb
`default_nettype wire
